/* dv/ptsel_asserts.sv */
// port assertions for the partition tag select block
// assumes bind into ptsel, one clock, async active-high reset
`timescale 1ns/1ps
module ptsel_asserts (
   input logic clk, input logic rst, input logic clk_en, input logic req_valid,
   input logic req_ready, input logic [2:0] req_kind, input logic stage1_en,
   input logic stage2_en, input logic stage1_partition_select,
   input logic security_flag_capability, input logic [15:0] stream_table_entry_partition_id,
   input logic [15:0] context_descriptor_partition_id, input logic map_rd_valid,
   input logic [15:0] map_rd_index, input logic map_rsp_valid,
   input logic [15:0] map_rsp_partition_id, input logic out_valid,
   input logic [15:0] out_partition_id, input logic out_partition_security_flag,
   input logic out_secure);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire take = clk_en & req_valid & req_ready;
   wire nest = stage1_en & stage2_en & stage1_partition_select;
   property p_ns; out_valid & !out_secure |-> out_partition_security_flag; endproperty
   a_ns: assert property (p_ns) else $error("nonsecure flag low");
   property p_cap0; out_valid & out_secure & !security_flag_capability |-> !out_partition_security_flag; endproperty
   a_cap0: assert property (p_cap0) else $error("secure flag high");
   property p_map; take & req_kind == 3'h0 & nest |=> map_rd_valid & !out_valid & map_rd_index == $past(context_descriptor_partition_id); endproperty
   a_map: assert property (p_map) else $error("no map lookup");
   property p_mapout; map_rd_valid & map_rsp_valid & clk_en |=> out_valid & out_partition_id == $past(map_rsp_partition_id); endproperty
   a_mapout: assert property (p_mapout) else $error("map tag wrong");
   property p_walk; take & req_kind == 3'h0 & !nest |=> out_valid & out_partition_id == $past(stream_table_entry_partition_id); endproperty
   a_walk: assert property (p_walk) else $error("walk tag wrong");
   property p_ctx; take & (req_kind == 3'h1 | req_kind == 3'h2) |=> out_partition_id == $past(stream_table_entry_partition_id); endproperty
   a_ctx: assert property (p_ctx) else $error("context tag wrong");
   property p_ready; map_rd_valid |-> !req_ready; endproperty
   a_ready: assert property (p_ready) else $error("ready during lookup");
   property p_stall; map_rd_valid & !map_rsp_valid |=> map_rd_valid & !out_valid; endproperty
   a_stall: assert property (p_stall) else $error("lookup dropped");
endmodule
bind ptsel ptsel_asserts i_ptsel_asserts (.*);

/* dv/ptsel_far_model.sv */
// far side: answers map lookups and accepts tags, optionally slowly
// assumes one clock and async active-high reset
`timescale 1ns/1ps
module ptsel_far_model (
   input wire clk, input wire rst, input wire slow, input wire map_rd_valid,
   input wire [15:0] map_rd_index, output reg map_rsp_valid,
   output reg [15:0] map_rsp_partition_id, output reg out_ready);
   reg [1:0] cnt_reg;
   wire pend = map_rd_valid & !map_rsp_valid;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 2'h0;
         map_rsp_valid <= 1'b0;
         map_rsp_partition_id <= 16'h0;
         out_ready <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         out_ready <= !slow | cnt_reg[1];
         map_rsp_valid <= pend & (!slow | &cnt_reg);
         // toggles when idle so stale data never matches
         map_rsp_partition_id <= pend ? map_rd_index ^ 16'h5a5a : ~map_rsp_partition_id;
      end
   end
endmodule

/* dv/tb.sv */
// self-checking bench for the partition tag select block
// assumes ptsel, its checker and ptsel_far_model compiled alongside
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_secure = 1'b0;
   reg [2:0] req_kind = 3'h0;
   reg [6:0] c = 7'h0;
   integer fails = 0, n_compared = 0, n, k, s;
   wire rdy, mrv, mrsv, ordy, ov, of, os;
   wire [15:0] mri, mrp, op, lnp, lsp;
   wire [7:0] og, lng, lsg;
   wire [15:0] v = {c, req_kind, req_secure, 5'h15};
   always #2.5 clk = ~clk;
   function [15:0] fp(input [3:0] i); fp = v ^ {4{i}}; endfunction
   function [7:0] fg(input [3:0] i); fg = v[7:0] ^ {2{i}}; endfunction
   function [25:0] want(input [2:0] kk, input ss);
      reg sec, f;
      reg [3:0] i;
      begin
         sec = (kk == 3'h7) ? !(c[4] | c[5]) : ss;
         i = kk < 3'h4 ? 4'h1 : kk == 3'h7 ? 4'h7 : (kk == 3'h6 ? 4'h5 : 4'h3) + sec;
         f = kk < 3'h4 ? c[3] : kk == 3'h7 ? c[5] ^ c[3] : kk == 3'h6 ? ~c[3] : c[6];
         want = {sec, (kk == 3'h0 && c[1:0] == 2'h3 && !c[6]) ? fp(4'h2) ^ 16'h5a5a : fp(i),
            fg(kk == 3'h0 && c[1] && !c[6] ? 4'h2 : i), !sec | (c[2] & f)};
      end
   endfunction
   // c[6] also turns stage 1 off, so stage-2-only and untranslated walks are covered
   ptsel #(.CG_NS_PART_MAX(16'h00f0), .CG_NS_GRP_MAX(8'h0e), .CG_S_PART_MAX(16'h0070),
      .CG_S_GRP_MAX(8'h06)) i_ptsel (.clk(clk), .rst(rst), .clk_en(1'b1), .req_valid(req_valid),
      .req_ready(rdy), .req_kind(req_kind), .req_secure(req_secure), .stage1_en(!c[6]),
      .stage2_en(c[0]), .stage1_partition_select(c[1]),
      .stream_table_entry_partition_id(fp(4'h1)), .stream_table_entry_monitor_group(fg(4'h1)),
      .stream_table_entry_partition_security_flag(c[3]),
      .context_descriptor_partition_id(fp(4'h2)), .context_descriptor_monitor_group(fg(4'h2)),
      .security_flag_capability(c[2]), .unit_originated_partition_id_ns(fp(4'h3)),
      .unit_originated_monitor_group_ns(fg(4'h3)), .unit_originated_partition_id_s(fp(4'h4)),
      .unit_originated_monitor_group_s(fg(4'h4)), .secure_global_partition_flag(c[6]),
      .bypass_partition_id_ns(fp(4'h5)), .bypass_monitor_group_ns(fg(4'h5)),
      .bypass_partition_id_s(fp(4'h6)), .bypass_monitor_group_s(fg(4'h6)),
      .secure_bypass_partition_flag(~c[3]), .counter_group_partition_id(fp(4'h7)),
      .counter_group_monitor_group(fg(4'h7)), .interrupt_write_security_select(c[4]),
      .nonsecure_access_permit(c[5]), .interrupt_partition_security_flag(c[5] ^ c[3]),
      .map_rd_valid(mrv), .map_rd_index(mri), .map_rsp_valid(mrsv),
      .map_rsp_partition_id(mrp), .out_valid(ov), .out_ready(ordy), .out_partition_id(op),
      .out_monitor_group(og), .out_partition_security_flag(of), .out_secure(os),
      .cg_limit_ns_partition_id(lnp), .cg_limit_ns_monitor_group(lng),
      .cg_limit_s_partition_id(lsp), .cg_limit_s_monitor_group(lsg));
   ptsel_far_model i_ptsel_far_model (.clk(clk), .rst(rst), .slow(c[4]), .map_rd_valid(mrv),
      .map_rd_index(mri), .map_rsp_valid(mrsv), .map_rsp_partition_id(mrp), .out_ready(ordy));
   task cmp(input logic [47:0] g, input logic [47:0] e);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task wrap_up;
      begin
         if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // one request; config only moves once the previous tag has drained
   task req(input [2:0] kk, input ss);
      integer t;
      reg r;
      begin
         @(posedge clk);
         req_kind <= kk;
         req_secure <= ss;
         req_valid <= 1'b1;
         t = 0;
         r = 1'b0;
         while (r !== 1'b1 && t < 40) begin
            @(negedge clk);
            r = rdy;
            @(posedge clk);
            t = t + 1;
         end
         req_valid <= 1'b0;
         while (ov !== 1'b1 && t < 40) begin @(negedge clk); t = t + 1; end
         cmp({os, op, og, of}, want(kk, ss));
         while (ov !== 1'b0 && t < 40) begin @(negedge clk); t = t + 1; end
         if (t >= 40) begin fails = fails + 1; wrap_up; end
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cmp({lnp, lng, lsp, lsg}, {16'h00f0, 8'h0e, 16'h0070, 8'h06});
      for (n = 0; n < 128; n = n + 1) begin
         @(posedge clk);
         c <= n[6:0];
         for (k = 0; k < 8; k = k + 1)
            for (s = 0; s < 2; s = s + 1)
               req(k[2:0], s[0]);
      end
      wrap_up;
   end
endmodule

/* hw/ptsel.v */
// partition tag selection for unit-originated requests and counter group writes
// assumes requests, config and map responses are synchronous to clk
`timescale 1ns/1ps
`include "ptsel_regs.vh"
module ptsel #(
   parameter PW = `PTSEL_PART_W,
   parameter GW = `PTSEL_GRP_W,
   parameter [PW-1:0] CG_NS_PART_MAX = `PTSEL_PART_MAX,
   parameter [GW-1:0] CG_NS_GRP_MAX = `PTSEL_GRP_MAX,
   parameter [PW-1:0] CG_S_PART_MAX = `PTSEL_PART_MAX,
   parameter [GW-1:0] CG_S_GRP_MAX = `PTSEL_GRP_MAX,
   parameter CG_HAS_PART = 1'b1,
   parameter CG_TWO_SEC = 1'b1
) (
   input wire clk,
   input wire rst,
   input wire clk_en,
   input wire req_valid,
   output wire req_ready,
   input wire [`PTSEL_KIND_W-1:0] req_kind,
   input wire req_secure,
   input wire stage1_en,
   input wire stage2_en,
   input wire stage1_partition_select,
   input wire [PW-1:0] stream_table_entry_partition_id,
   input wire [GW-1:0] stream_table_entry_monitor_group,
   input wire stream_table_entry_partition_security_flag,
   input wire [PW-1:0] context_descriptor_partition_id,
   input wire [GW-1:0] context_descriptor_monitor_group,
   input wire security_flag_capability,
   input wire [PW-1:0] unit_originated_partition_id_ns,
   input wire [GW-1:0] unit_originated_monitor_group_ns,
   input wire [PW-1:0] unit_originated_partition_id_s,
   input wire [GW-1:0] unit_originated_monitor_group_s,
   input wire secure_global_partition_flag,
   input wire [PW-1:0] bypass_partition_id_ns,
   input wire [GW-1:0] bypass_monitor_group_ns,
   input wire [PW-1:0] bypass_partition_id_s,
   input wire [GW-1:0] bypass_monitor_group_s,
   input wire secure_bypass_partition_flag,
   input wire [PW-1:0] counter_group_partition_id,
   input wire [GW-1:0] counter_group_monitor_group,
   input wire interrupt_write_security_select,
   input wire nonsecure_access_permit,
   input wire interrupt_partition_security_flag,
   output reg map_rd_valid,
   output reg [PW-1:0] map_rd_index,
   input wire map_rsp_valid,
   input wire [PW-1:0] map_rsp_partition_id,
   output reg out_valid,
   input wire out_ready,
   output reg [PW-1:0] out_partition_id,
   output reg [GW-1:0] out_monitor_group,
   output reg out_partition_security_flag,
   output reg out_secure,
   output wire [PW-1:0] cg_limit_ns_partition_id,
   output wire [GW-1:0] cg_limit_ns_monitor_group,
   output wire [PW-1:0] cg_limit_s_partition_id,
   output wire [GW-1:0] cg_limit_s_monitor_group
);

   // flag for a request of the given security state and controlling field
   function flag_sel;
      input sec;
      input cap;
      input field_flag;
      begin
         if (!sec)
            flag_sel = 1'b1;
         else if (!cap)
            flag_sel = 1'b0;
         else
            flag_sel = field_flag;
      end
   endfunction

   // secure or nonsecure copy of a partition field
   function [PW-1:0] pick_part;
      input sec;
      input [PW-1:0] val_s;
      input [PW-1:0] val_ns;
      begin
         if (sec)
            pick_part = val_s;
         else
            pick_part = val_ns;
      end
   endfunction

   // secure or nonsecure copy of a monitor group field
   function [GW-1:0] pick_grp;
      input sec;
      input [GW-1:0] val_s;
      input [GW-1:0] val_ns;
      begin
         if (sec)
            pick_grp = val_s;
         else
            pick_grp = val_ns;
      end
   endfunction

   // context group replaces the entry group whenever stage 1 runs with select set
   function walk_ctx_grp;
      input s1;
      input s2;
      input sel;
      begin
         if (s1 && s2)
            walk_ctx_grp = sel;
         else if (s1)
            walk_ctx_grp = sel;
         else
            walk_ctx_grp = 1'b0;
      end
   endfunction

   // counter group flag: own control bit, or without partitioning the nonsecure state (1 if CG_TWO_SEC is 0)
   function cg_flag;
      input nonsec;
      input cap;
      input field_flag;
      begin
         if (!CG_HAS_PART)
            cg_flag = CG_TWO_SEC ? nonsec : 1'b1;
         else
            cg_flag = flag_sel(!nonsec, cap, field_flag);
      end
   endfunction

   localparam [`PTSEL_ST_W-1:0] ST_IDLE = `PTSEL_ST_IDLE;
   localparam [`PTSEL_ST_W-1:0] ST_MAP = `PTSEL_ST_MAP;
   localparam [`PTSEL_ST_W-1:0] ST_OUT = `PTSEL_ST_OUT;

   reg [`PTSEL_ST_W-1:0] state_reg;
   reg [`PTSEL_ST_W-1:0] state_next;
   reg [PW-1:0] part_next;
   reg [GW-1:0] grp_next;
   reg flag_next;
   reg sec_next;
   reg need_map;
   reg cg_nonsec;
   reg hold_flag_reg;
   reg hold_sec_reg;
   reg [GW-1:0] hold_grp_reg;

   wire take = req_valid && req_ready;
   wire nested = stage1_en && stage2_en;

   // caches are shared by all partitions; the optional split is not built
   assign req_ready = (state_reg == ST_IDLE) ||
      ((state_reg == ST_OUT) && out_ready);

   // limits are fixed by the build, so they cost no state
   assign cg_limit_ns_partition_id = CG_NS_PART_MAX;
   assign cg_limit_ns_monitor_group = CG_NS_GRP_MAX;
   assign cg_limit_s_partition_id = CG_S_PART_MAX;
   assign cg_limit_s_monitor_group = CG_S_GRP_MAX;

   always @* begin
      part_next = {PW{1'b0}};
      grp_next = {GW{1'b0}};
      flag_next = 1'b1;
      sec_next = req_secure;
      need_map = 1'b0;
      cg_nonsec = interrupt_write_security_select || nonsecure_access_permit;
      case (req_kind)
         `PTSEL_K_WALK: begin
            flag_next = flag_sel(req_secure, security_flag_capability,
               stream_table_entry_partition_security_flag);
            part_next = stream_table_entry_partition_id;
            grp_next = stream_table_entry_monitor_group;
            // nested walks with select set wait for the map: one extra access before the walk
            need_map = nested && stage1_partition_select;
            if (walk_ctx_grp(stage1_en, stage2_en, stage1_partition_select))
               grp_next = context_descriptor_monitor_group;
         end
         `PTSEL_K_LEVEL1_CONTEXT_DESCRIPTOR, `PTSEL_K_CD, `PTSEL_K_VMS: begin
            part_next = stream_table_entry_partition_id;
            grp_next = stream_table_entry_monitor_group;
            flag_next = flag_sel(req_secure, security_flag_capability,
               stream_table_entry_partition_security_flag);
         end
         `PTSEL_K_QUEUE, `PTSEL_K_UMSI: begin
            part_next = pick_part(req_secure, unit_originated_partition_id_s,
               unit_originated_partition_id_ns);
            grp_next = pick_grp(req_secure, unit_originated_monitor_group_s,
               unit_originated_monitor_group_ns);
            flag_next = flag_sel(req_secure, security_flag_capability,
               secure_global_partition_flag);
         end
         `PTSEL_K_BYPASS: begin
            part_next = pick_part(req_secure, bypass_partition_id_s, bypass_partition_id_ns);
            grp_next = pick_grp(req_secure, bypass_monitor_group_s, bypass_monitor_group_ns);
            flag_next = flag_sel(req_secure, security_flag_capability,
               secure_bypass_partition_flag);
         end
         `PTSEL_K_CGMSI: begin
            // the write's own attribute decides, not the request's state
            sec_next = !cg_nonsec;
            flag_next = cg_flag(cg_nonsec, security_flag_capability,
               interrupt_partition_security_flag);
            if (CG_HAS_PART) begin
               part_next = counter_group_partition_id;
               grp_next = counter_group_monitor_group;
            end else begin
               part_next = {PW{1'b0}};
               grp_next = {GW{1'b0}};
            end
         end
         default: begin
            part_next = {PW{1'b0}};
         end
      endcase
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take)
               state_next = need_map ? ST_MAP : ST_OUT;
         end
         ST_OUT: begin
            // a new request may be taken in the cycle the tag leaves
            if (take)
               state_next = need_map ? ST_MAP : ST_OUT;
            else if (out_ready)
               state_next = ST_IDLE;
         end
         ST_MAP: begin
            if (map_rsp_valid)
               state_next = ST_OUT;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // valid follows the next state, so tag and valid rise on the same edge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         out_valid <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         out_valid <= (state_next == ST_OUT);
      end
   end

   // lookup request stands until the map answers; no time limit is imposed
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         map_rd_valid <= 1'b0;
         map_rd_index <= {PW{1'b0}};
      end else if (clk_en) begin
         if (take && need_map) begin
            map_rd_valid <= 1'b1;
            map_rd_index <= context_descriptor_partition_id;
         end else if (state_reg == ST_MAP && map_rsp_valid) begin
            map_rd_valid <= 1'b0;
         end
      end
   end

   // walk fields are captured at the take, so config moving during the lookup cannot leak in
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_flag_reg <= 1'b0;
         hold_sec_reg <= 1'b0;
         hold_grp_reg <= {GW{1'b0}};
      end else if (clk_en) begin
         if (take && need_map) begin
            hold_flag_reg <= flag_next;
            hold_sec_reg <= sec_next;
            hold_grp_reg <= grp_next;
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_partition_id <= {PW{1'b0}};
         out_monitor_group <= {GW{1'b0}};
         out_partition_security_flag <= 1'b0;
         out_secure <= 1'b0;
      end else if (clk_en) begin
         if (take && !need_map) begin
            out_partition_id <= part_next;
            out_monitor_group <= grp_next;
            out_partition_security_flag <= flag_next;
            out_secure <= sec_next;
         end else if (state_reg == ST_MAP && map_rsp_valid) begin
            // walk tag waits for the physical partition from the map
            out_partition_id <= map_rsp_partition_id;
            out_monitor_group <= hold_grp_reg;
            out_partition_security_flag <= hold_flag_reg;
            out_secure <= hold_sec_reg;
         end
      end
   end

endmodule

/* hw/ptsel_regs.vh */
// constants for the partition tag select block
// assumes a single clock domain; included by hw/ptsel.v
// Contract
// - both stages, select 1: walk tag = map[context partition], context group
// - both stages, select 0: walk tag = entry partition and entry group
// - stage 1 only: entry partition; group from context if select 1, else entry
// - nested select 1: map lookup access precedes the stage 1 walk tag
// - counter group writes use its one config partition and group for either write security
// - counter group write security from security select and access permit bits
// - counter group reports nonsecure and secure partition and group limits
// - counter group without partitioning: partition 0, group 0, flag rule
// - every nonsecure request carries security flag 1
// - capability 0: every secure request carries security flag 0
// - capability 1: secure flag comes from the controlling field's flag
// - secure partition and group come from the same fields as without flags
// - four flag bits: bypass, global, stream entry, counter group interrupt
// - context and vm structure fetches inherit the stream entry flag
// - internal partitioning is implementation defined; not used here
// - queue and unit interrupt writes use unit-originated global fields
// - level 1 context and context fetches use stream entry fields
`ifndef PTSEL_REGS_VH
`define PTSEL_REGS_VH
`define PTSEL_KIND_W 3
`define PTSEL_K_WALK 3'h0
`define PTSEL_K_LEVEL1_CONTEXT_DESCRIPTOR 3'h1
`define PTSEL_K_CD 3'h2
`define PTSEL_K_VMS 3'h3
`define PTSEL_K_QUEUE 3'h4
`define PTSEL_K_UMSI 3'h5
`define PTSEL_K_BYPASS 3'h6
`define PTSEL_K_CGMSI 3'h7
`define PTSEL_ST_W 3
`define PTSEL_ST_IDLE 3'h1
`define PTSEL_ST_MAP 3'h2
`define PTSEL_ST_OUT 3'h4
`define PTSEL_PART_W 16
`define PTSEL_GRP_W 8
`define PTSEL_PART_MAX 16'hffff
`define PTSEL_GRP_MAX 8'hff
`endif
